// ==== inc/cfg_prog_pkg.sv ====
/*
  Constants for the configuration word serial programming block:
  command codes, frame lengths, decoded instruction words, register
  layouts and the default configuration values.
  Assumes nothing beyond a SystemVerilog compiler.
*/
package cfg_prog_pkg;
  // ==========================================================
  // Serial frame
  localparam int          CMD_BITS       = 4;
  localparam int          PAYLOAD_BITS   = 24;
  localparam int          OUT_BITS       = 16;
  localparam int          OUT_IDLE_EDGES = 8;
  localparam logic [3:0]  CMD_EXEC       = 4'h0;
  localparam logic [3:0]  CMD_REGOUT     = 4'h1;
  // ==========================================================
  // Instruction words the core understands
  localparam logic [23:0] OP_NOP         = 24'h000000;
  localparam logic [23:0] OP_GOTO_200    = 24'h040200;
  localparam logic [23:0] OP_MOV_W10_NVM = 24'h883b0a;
  localparam logic [23:0] OP_MOV_W0_PAGE = 24'h880190;
  localparam logic [23:0] OP_TABLE_WRITE_LOW_INSTR      = 24'hbb1b86;
  localparam logic [23:0] OP_BIT_SET_INSTR_WR     = 24'ha8e761;
  localparam logic [23:0] OP_MOV_NVM_W2  = 24'h803b02;
  localparam logic [23:0] OP_MOV_W2_VISI = 24'h883c22;
  localparam logic [3:0]  OP_MOV_LIT     = 4'h2;
  // ==========================================================
  // Register indices and fields
  localparam int          W_PAGE_SCRATCH = 0;
  localparam int          W_POLL_SCRATCH = 2;
  localparam int          W_DATA_HOLD    = 6;
  localparam int          W_WRITE_PTR    = 7;
  localparam int          W_CTRL_SCRATCH = 10;
  localparam int          NVM_WR_BIT     = 15;
  localparam logic [15:0] NVM_WORD_WRITE = 16'h4003;
  localparam logic [15:0] PTR_STEP       = 16'h0002;
  // ==========================================================
  // Configuration words, index 0 is the first word
  localparam int          CFG_WORDS      = 3;
  localparam logic [15:0] CW1_DEFAULT    = 16'h7fff;
  localparam logic [15:0] CW2_DEFAULT    = 16'hf7ff;
  localparam logic [15:0] CW3_DEFAULT    = 16'hffff;
  localparam logic [15:0] CW_STRIDE      = 16'h0002;
  localparam logic [15:0] LAST_WORD_LOW  = 16'hfffe;
  localparam logic [7:0]  CFG_PAGE       = 8'h01;
  localparam int          WRITE_CYCLES   = 64;
endpackage : cfg_prog_pkg

// ==== hw/prog_serial_port.sv ====
/*
  Serial front end of the programming port: synchronises the programming
  clock and data pins, assembles command and payload frames and shifts
  the visible output word back out.
  Assumes the programming clock is far slower than mclk_in.
*/
`timescale 1ns/1ps
module prog_serial_port (
  // Clock and reset
  input  wire logic        mclk_in,
  input  wire logic        rst_in,
  // Pins
  input  wire logic        pclk_pin_in,
  input  wire logic        pdata_pin_in,
  output logic             pdata_pin_out,
  output logic             pdata_pin_oe_out,
  // Core side
  input  wire logic [15:0] visi_in,
  output logic             frame_valid_out,
  output logic [23:0]      frame_payload_out
);
  typedef enum logic [1:0] {
    RX_CMD  = 2'b00,
    RX_DATA = 2'b01,
    TX_OUT  = 2'b10,
    TX_END  = 2'b11
  } port_state_e;

  // ==========================================================
  // Pin synchronisers
  logic [2:0] clk_sync_reg;
  logic [1:0] dat_sync_reg;
  always_ff @(posedge mclk_in) begin
    clk_sync_reg <= {clk_sync_reg[1:0], pclk_pin_in};
    dat_sync_reg <= {dat_sync_reg[0], pdata_pin_in};
  end
  logic rise;
  logic fall;
  logic din;
  assign rise = clk_sync_reg[1] & ~clk_sync_reg[2];
  assign fall = ~clk_sync_reg[1] & clk_sync_reg[2];
  assign din  = dat_sync_reg[1];

  // ==========================================================
  // Frame engine
  port_state_e state_reg, state_next;
  logic [4:0]  cnt_reg, cnt_next;
  logic [3:0]  cmd_reg, cmd_next;
  logic [23:0] pay_reg, pay_next;
  logic [15:0] sh_reg, sh_next;
  logic        out_reg, out_next;
  logic        oe_reg, oe_next;
  logic        valid_reg, valid_next;
  logic        keep_reg, keep_next;

  always_comb begin
    state_next = state_reg;
    cnt_next   = cnt_reg;
    cmd_next   = cmd_reg;
    pay_next   = pay_reg;
    sh_next    = sh_reg;
    out_next   = out_reg;
    oe_next    = oe_reg;
    valid_next = 1'b0;
    keep_next  = keep_reg;
    unique case (state_reg)
      RX_CMD: begin
        if (rise) begin
          cmd_next = {din, cmd_reg[3:1]};
          cnt_next = cnt_reg + 5'd1;
          if (cnt_reg == 5'(cfg_prog_pkg::CMD_BITS - 1)) begin
            cnt_next = 5'd0;
            // Unknown codes still swallow a payload so framing holds
            keep_next  = ({din, cmd_reg[3:1]} == cfg_prog_pkg::CMD_EXEC);
            state_next = ({din, cmd_reg[3:1]} == cfg_prog_pkg::CMD_REGOUT) ? TX_OUT
                                                                           : RX_DATA;
          end
        end
      end
      RX_DATA: begin
        if (rise) begin
          pay_next = {din, pay_reg[23:1]};
          cnt_next = cnt_reg + 5'd1;
          if (cnt_reg == 5'(cfg_prog_pkg::PAYLOAD_BITS - 1)) begin
            cnt_next   = 5'd0;
            valid_next = keep_reg;
            state_next = RX_CMD;
          end
        end
      end
      TX_OUT: begin
        if (rise) begin
          cnt_next = cnt_reg + 5'd1;
          if (cnt_reg == 5'(cfg_prog_pkg::OUT_IDLE_EDGES - 1)) begin
            sh_next  = {1'b0, visi_in[15:1]};
            out_next = visi_in[0];
            oe_next  = 1'b1;
          end else if (cnt_reg >= 5'(cfg_prog_pkg::OUT_IDLE_EDGES)) begin
            sh_next  = {1'b0, sh_reg[15:1]};
            out_next = sh_reg[0];
          end
          if (cnt_reg == 5'(cfg_prog_pkg::PAYLOAD_BITS - 1)) begin
            cnt_next   = 5'd0;
            state_next = TX_END;
          end
        end
      end
      TX_END: begin
        // Release the pin on the falling edge after the last bit
        if (fall) begin
          oe_next    = 1'b0;
          state_next = RX_CMD;
        end
      end
    endcase
  end

  always_ff @(posedge mclk_in) begin
    if (rst_in) begin
      state_reg <= RX_CMD;
      cnt_reg   <= 5'd0;
      cmd_reg   <= 4'h0;
      pay_reg   <= 24'h000000;
      sh_reg    <= 16'h0000;
      out_reg   <= 1'b0;
      oe_reg    <= 1'b0;
      valid_reg <= 1'b0;
      keep_reg  <= 1'b0;
    end else begin
      state_reg <= state_next;
      cnt_reg   <= cnt_next;
      cmd_reg   <= cmd_next;
      pay_reg   <= pay_next;
      sh_reg    <= sh_next;
      out_reg   <= out_next;
      oe_reg    <= oe_next;
      valid_reg <= valid_next;
      keep_reg  <= keep_next;
    end
  end

  assign pdata_pin_out     = out_reg;
  assign pdata_pin_oe_out  = oe_reg;
  assign frame_valid_out   = valid_reg;
  assign frame_payload_out = pay_reg;

  // ==========================================================
  // Checks
  default clocking cb @(posedge mclk_in); endclocking
  default disable iff (rst_in);

  property p_lsb_last_bit;
    rise && state_reg == RX_DATA && cnt_reg == 5'd23 && keep_reg
      |=> frame_valid_out && frame_payload_out[23] == $past(din);
  endproperty
  a_lsb_last_bit: assert property (p_lsb_last_bit)
    else $error("last payload bit not stored at the top");

  sequence s_out_start;
    rise && state_reg == TX_OUT && cnt_reg == 5'd7;
  endsequence
  property p_out_first;
    s_out_start |=> pdata_pin_oe_out && pdata_pin_out == $past(visi_in[0]);
  endproperty
  a_out_first: assert property (p_out_first)
    else $error("output word did not start with its low bit");
endmodule : prog_serial_port

// ==== hw/cfg_word_programmer.sv ====
/*
  Configuration word programming through the serial programming port:
  a tiny instruction executor, the nonvolatile control register, the
  write latch, the configuration Flash words and the configuration
  registers reloaded at every reset.
  Assumes chip_erase_in is pulsed once before use to give the Flash a
  defined content; rst_in does not touch the Flash words.
*/
`timescale 1ns/1ps
module cfg_word_programmer #(
  parameter int          WRITE_CYCLES  = cfg_prog_pkg::WRITE_CYCLES,
  parameter logic [15:0] LAST_WORD_LOW = cfg_prog_pkg::LAST_WORD_LOW,
  parameter logic [7:0]  CFG_PAGE      = cfg_prog_pkg::CFG_PAGE
) (
  // Clock and reset
  input  wire logic        mclk_in,
  input  wire logic        rst_in,
  input  wire logic        chip_erase_in,
  // Programming pins
  input  wire logic        programming_clock_pin_in,
  input  wire logic        programming_data_pin_in,
  output logic             programming_data_pin_out,
  output logic             programming_data_pin_oe_out,
  // Configuration registers
  output logic [15:0]      config_word_one_out,
  output logic [15:0]      config_word_two_out,
  output logic [15:0]      config_word_three_out,
  output logic             config_loaded_out
);
  localparam int          N      = cfg_prog_pkg::CFG_WORDS;
  localparam logic [15:0] BUSY_N = 16'(WRITE_CYCLES);
  localparam logic [15:0] DEFS [N] = '{cfg_prog_pkg::CW1_DEFAULT,
                                       cfg_prog_pkg::CW2_DEFAULT,
                                       cfg_prog_pkg::CW3_DEFAULT};

  // ==========================================================
  // Serial port
  logic        fv;
  logic [23:0] op;
  logic [15:0] visi_reg, visi_next;
  prog_serial_port u_port (
    .mclk_in           (mclk_in),
    .rst_in            (rst_in),
    .pclk_pin_in       (programming_clock_pin_in),
    .pdata_pin_in      (programming_data_pin_in),
    .pdata_pin_out     (programming_data_pin_out),
    .pdata_pin_oe_out  (programming_data_pin_oe_out),
    .visi_in           (visi_reg),
    .frame_valid_out   (fv),
    .frame_payload_out (op)
  );

  // ==========================================================
  // Instruction executor and write engine
  logic [15:0] wreg_reg [16];
  logic [15:0] wreg_next [16];
  logic [7:0]  page_reg, page_next;
  logic [15:0] nvm_reg, nvm_next;
  logic [23:0] laddr_reg, laddr_next;
  logic [15:0] ldata_reg, ldata_next;
  logic        lvalid_reg, lvalid_next;
  logic [15:0] busy_reg, busy_next;
  logic        commit;

  always_comb begin
    wreg_next   = wreg_reg;
    page_next   = page_reg;
    nvm_next    = nvm_reg;
    visi_next   = visi_reg;
    laddr_next  = laddr_reg;
    ldata_next  = ldata_reg;
    lvalid_next = lvalid_reg;
    busy_next   = busy_reg;
    commit      = 1'b0;
    if (busy_reg != 16'h0000) begin
      busy_next = busy_reg - 16'h0001;
      if (busy_reg == 16'h0001) begin
        commit                            = 1'b1;
        nvm_next[cfg_prog_pkg::NVM_WR_BIT] = 1'b0;
        lvalid_next                       = 1'b0;
      end
    end
    if (fv) begin
      if (op[23:20] == cfg_prog_pkg::OP_MOV_LIT) begin
        wreg_next[op[3:0]] = op[19:4];
      end else if (op == cfg_prog_pkg::OP_MOV_W0_PAGE) begin
        page_next = wreg_reg[cfg_prog_pkg::W_PAGE_SCRATCH][7:0];
      end else if (op == cfg_prog_pkg::OP_MOV_W10_NVM) begin
        // Busy bit is only set by the bit-set and cleared by hardware
        nvm_next[14:0] = wreg_reg[cfg_prog_pkg::W_CTRL_SCRATCH][14:0];
      end else if (op == cfg_prog_pkg::OP_TABLE_WRITE_LOW_INSTR) begin
        laddr_next  = {page_reg, wreg_reg[cfg_prog_pkg::W_WRITE_PTR]};
        ldata_next  = wreg_reg[cfg_prog_pkg::W_DATA_HOLD];
        lvalid_next = 1'b1;
        wreg_next[cfg_prog_pkg::W_WRITE_PTR] =
          wreg_reg[cfg_prog_pkg::W_WRITE_PTR] + cfg_prog_pkg::PTR_STEP;
      end else if (op == cfg_prog_pkg::OP_BIT_SET_INSTR_WR) begin
        if (!nvm_reg[cfg_prog_pkg::NVM_WR_BIT]) begin
          nvm_next[cfg_prog_pkg::NVM_WR_BIT] = 1'b1;
          busy_next                         = BUSY_N;
        end
      end else if (op == cfg_prog_pkg::OP_MOV_NVM_W2) begin
        wreg_next[cfg_prog_pkg::W_POLL_SCRATCH] = nvm_reg;
      end else if (op == cfg_prog_pkg::OP_MOV_W2_VISI) begin
        visi_next = wreg_reg[cfg_prog_pkg::W_POLL_SCRATCH];
      end
      // No-op and jump to the reset target leave all state alone
    end
  end

  always_ff @(posedge mclk_in) begin
    if (rst_in) begin
      for (int i = 0; i < 16; i++) begin
        wreg_reg[i] <= 16'h0000;
      end
      page_reg   <= 8'h00;
      nvm_reg    <= 16'h0000;
      visi_reg   <= 16'h0000;
      laddr_reg  <= 24'h000000;
      ldata_reg  <= 16'h0000;
      lvalid_reg <= 1'b0;
      busy_reg   <= 16'h0000;
    end else begin
      wreg_reg   <= wreg_next;
      page_reg   <= page_next;
      nvm_reg    <= nvm_next;
      visi_reg   <= visi_next;
      laddr_reg  <= laddr_next;
      ldata_reg  <= ldata_next;
      lvalid_reg <= lvalid_next;
      busy_reg   <= busy_next;
    end
  end

  // ==========================================================
  // Flash words and configuration registers
  // Flash is nonvolatile, so rst_in leaves it alone; a reset during a
  // write aborts it unless it lands on the final busy cycle, whose commit still clears the bits.
  logic [15:0] flash_reg [N];
  logic [15:0] cfg_reg [N];
  logic [1:0]  ld_reg, ld_next;
  logic        done_reg, done_next;

  genvar g;
  generate
    for (g = 0; g < N; g++) begin : g_word
      logic        hit;
      logic [15:0] fl_next;
      logic [15:0] cf_next;
      assign hit = commit && lvalid_reg
                   && nvm_reg == (cfg_prog_pkg::NVM_WORD_WRITE
                                  | 16'h8000)
                   && laddr_reg == {CFG_PAGE,
                                    16'(LAST_WORD_LOW - 16'(g) * cfg_prog_pkg::CW_STRIDE)};
      always_comb begin
        fl_next = flash_reg[g];
        if (chip_erase_in) begin
          fl_next = DEFS[g];
        end else if (hit) begin
          fl_next = flash_reg[g] & ldata_reg;
        end
        cf_next = cfg_reg[g];
        if (!done_reg && ld_reg == 2'(g)) begin
          cf_next = flash_reg[g];
        end
      end
      always_ff @(posedge mclk_in) begin
        flash_reg[g] <= fl_next;
        if (rst_in) begin
          cfg_reg[g] <= DEFS[g];
        end else begin
          cfg_reg[g] <= cf_next;
        end
      end
    end
  endgenerate

  always_comb begin
    ld_next   = ld_reg;
    done_next = done_reg;
    if (!done_reg) begin
      ld_next = ld_reg + 2'd1;
      if (ld_reg == 2'(N - 1)) begin
        done_next = 1'b1;
      end
    end
  end

  always_ff @(posedge mclk_in) begin
    if (rst_in) begin
      ld_reg   <= 2'd0;
      done_reg <= 1'b0;
    end else begin
      ld_reg   <= ld_next;
      done_reg <= done_next;
    end
  end

  assign config_word_one_out   = cfg_reg[0];
  assign config_word_two_out   = cfg_reg[1];
  assign config_word_three_out = cfg_reg[2];
  assign config_loaded_out     = done_reg;

  // ==========================================================
  // Checks
  default clocking cb @(posedge mclk_in); endclocking
  default disable iff (rst_in);

  property p_reload;
    $fell(rst_in) |-> ##3 config_loaded_out && config_word_one_out == $past(flash_reg[0], 3);
  endproperty
  a_reload: assert property (p_reload)
    else $error("configuration not reloaded after reset");

  property p_stable;
    config_loaded_out |=> $stable(config_word_two_out) && $stable(config_word_one_out)
                          && $stable(config_word_three_out);
  endproperty
  a_stable: assert property (p_stable)
    else $error("configuration register changed without reset");

  property p_clear_only;
    !$past(chip_erase_in) |-> (flash_reg[1] & ~$past(flash_reg[1])) == 16'h0000;
  endproperty
  a_clear_only: assert property (p_clear_only)
    else $error("programming set a Flash bit");

  property p_defaults;
    chip_erase_in |=> flash_reg[0] == cfg_prog_pkg::CW1_DEFAULT
                      && flash_reg[1] == cfg_prog_pkg::CW2_DEFAULT
                      && flash_reg[2] == cfg_prog_pkg::CW3_DEFAULT;
  endproperty
  a_defaults: assert property (p_defaults)
    else $error("erase did not restore default words");

  sequence s_start;
    fv && op == cfg_prog_pkg::OP_BIT_SET_INSTR_WR && !nvm_reg[15];
  endsequence
  property p_busy_held;
    s_start |=> nvm_reg[15] [*8];
  endproperty
  a_busy_held: assert property (p_busy_held)
    else $error("busy bit dropped early");

  property p_busy_clear;
    busy_reg == 16'h0001 |=> !nvm_reg[15] && busy_reg == 16'h0000;
  endproperty
  a_busy_clear: assert property (p_busy_clear)
    else $error("busy bit not cleared at write end");

  property p_visi;
    fv && op == cfg_prog_pkg::OP_MOV_W2_VISI |=> visi_reg == $past(wreg_reg[2]);
  endproperty
  a_visi: assert property (p_visi)
    else $error("output register not loaded");

  property p_latch;
    fv && op == cfg_prog_pkg::OP_TABLE_WRITE_LOW_INSTR
      |=> ldata_reg == $past(wreg_reg[6]) && wreg_reg[7] == $past(wreg_reg[7]) + 16'h0002;
  endproperty
  a_latch: assert property (p_latch)
    else $error("table write did not latch or advance pointer");
endmodule : cfg_word_programmer

// ==== bench/prog_pin_model.sv ====
/*
  Behavioural programmer on the far side of the programming pins: shifts
  command frames, reads the visible output word and runs the word write
  sequence for one configuration word.
  Assumes it is called just after a rising edge of mclk_in.
*/
`timescale 1ns/1ps
module prog_pin_model (
  // Clock
  input  wire logic mclk_in,
  // Device side of the data pin
  input  wire logic dev_data_in,
  input  wire logic dev_oe_in,
  // Pins as the device sees them
  output logic      pclk_out,
  output logic      pdata_out
);
  logic drv_reg;
  logic own_reg;
  logic last_reg;

  // ==========================================================
  // Pin level
  // A released line toggles so that no stale value can pass for data
  assign pdata_out = dev_oe_in ? dev_data_in : (own_reg ? drv_reg : ~last_reg);
  always @(posedge mclk_in) last_reg <= pdata_out;

  initial begin
    pclk_out = 1'b0;
    drv_reg  = 1'b0;
    own_reg  = 1'b1;
    last_reg = 1'b0;
  end

  // ==========================================================
  // Link clock period of 8 mclk, data set while low, sampled after fall
  task automatic bit_io(input logic b, output logic s);
    drv_reg <= b;
    repeat (2) @(posedge mclk_in);
    pclk_out <= 1'b1;
    repeat (4) @(posedge mclk_in);
    pclk_out <= 1'b0;
    repeat (2) @(posedge mclk_in);
    s = pdata_out;
  endtask : bit_io

  task automatic exec(input logic [23:0] op);
    logic s;
    for (int i = 0; i < 4; i++) bit_io(cfg_prog_pkg::CMD_EXEC[i], s);
    for (int i = 0; i < 24; i++) bit_io(op[i], s);
  endtask : exec

  task automatic read_visi(output logic [15:0] v);
    logic s;
    own_reg <= 1'b1;
    for (int i = 0; i < 4; i++) bit_io(cfg_prog_pkg::CMD_REGOUT[i], s);
    own_reg <= 1'b0;
    // Bit 0 appears at the twelfth rise and is taken after its fall
    for (int i = 0; i < 7; i++) bit_io(1'b0, s);
    for (int i = 0; i < 16; i++) begin
      bit_io(1'b0, s);
      v[i] = s;
    end
    // The 28th rise closes the frame
    bit_io(1'b0, s);
    repeat (4) @(posedge mclk_in);
    own_reg <= 1'b1;
  endtask : read_visi

  // ==========================================================
  // Word write of one configuration word, index 0 is word one
  task automatic program_word(input int idx, input logic [15:0] val,
                              output logic first_busy, output logic final_busy);
    logic [15:0] v;
    logic [15:0] addr;
    addr = cfg_prog_pkg::LAST_WORD_LOW - 16'(2 * idx);
    exec(cfg_prog_pkg::OP_NOP);
    exec(cfg_prog_pkg::OP_GOTO_200);
    exec(cfg_prog_pkg::OP_NOP);
    exec({4'h2, addr, 4'(cfg_prog_pkg::W_WRITE_PTR)});
    exec({4'h2, cfg_prog_pkg::NVM_WORD_WRITE, 4'(cfg_prog_pkg::W_CTRL_SCRATCH)});
    exec(cfg_prog_pkg::OP_MOV_W10_NVM);
    exec({4'h2, 8'h00, cfg_prog_pkg::CFG_PAGE, 4'(cfg_prog_pkg::W_PAGE_SCRATCH)});
    exec(cfg_prog_pkg::OP_MOV_W0_PAGE);
    exec({4'h2, val, 4'(cfg_prog_pkg::W_DATA_HOLD)});
    exec(cfg_prog_pkg::OP_NOP);
    exec(cfg_prog_pkg::OP_TABLE_WRITE_LOW_INSTR);
    repeat (2) exec(cfg_prog_pkg::OP_NOP);
    exec(cfg_prog_pkg::OP_BIT_SET_INSTR_WR);
    repeat (2) exec(cfg_prog_pkg::OP_NOP);
    first_busy = 1'b0;
    final_busy = 1'b1;
    // Bounded poll so a stuck busy bit cannot hang the run
    for (int p = 0; p < 4 && final_busy === 1'b1; p++) begin
      exec(cfg_prog_pkg::OP_GOTO_200);
      exec(cfg_prog_pkg::OP_NOP);
      exec(cfg_prog_pkg::OP_MOV_NVM_W2);
      exec(cfg_prog_pkg::OP_MOV_W2_VISI);
      exec(cfg_prog_pkg::OP_NOP);
      read_visi(v);
      exec(cfg_prog_pkg::OP_NOP);
      if (p == 0) first_busy = v[cfg_prog_pkg::NVM_WR_BIT];
      final_busy = v[cfg_prog_pkg::NVM_WR_BIT];
    end
    exec(cfg_prog_pkg::OP_GOTO_200);
    exec(cfg_prog_pkg::OP_NOP);
  endtask : program_word
endmodule : prog_pin_model

// ==== bench/tb_top.sv ====
/*
  Self-checking bench for the configuration word programmer: writes each
  word through the serial pins, polls the busy bit and checks the
  configuration registers after every reset.
  Assumes prog_pin_model drives the pins.
*/
`timescale 1ns/1ps
module tb_top;
  // ==========================================================
  // Signals
  // Long write so the first poll still sees the busy bit set
  localparam int WR_CYC = 2000;
  typedef struct packed {
    logic [1:0]  idx;
    logic [15:0] val;
    logic [15:0] e1;
    logic [15:0] e2;
    logic [15:0] e3;
  } row_s;
  // Values keep the reserved bits at their fixed levels
  localparam row_s ROWS [4] = '{
    '{2'd1, 16'hf7f7, 16'h7fff, 16'hf7f7, 16'hffff},
    '{2'd0, 16'h7ffe, 16'h7ffe, 16'hf7f7, 16'hffff},
    // Later word write clears more bits once the first is verified
    '{2'd0, 16'h7ff5, 16'h7ff4, 16'hf7f7, 16'hffff},
    '{2'd2, 16'h0ff0, 16'h7ff4, 16'hf7f7, 16'h0ff0}};
  logic        mclk_in;
  logic        rst_in;
  logic        chip_erase_in;
  logic        pclk;
  logic        pdata;
  logic        dev_out;
  logic        dev_oe;
  logic [15:0] cw1;
  logic [15:0] cw2;
  logic [15:0] cw3;
  logic        loaded;
  int          failures;
  int          n_checks;

  cfg_word_programmer #(.WRITE_CYCLES(WR_CYC)) cfg_word_programmer_inst (
    .mclk_in                     (mclk_in),
    .rst_in                      (rst_in),
    .chip_erase_in               (chip_erase_in),
    .programming_clock_pin_in    (pclk),
    .programming_data_pin_in     (pdata),
    .programming_data_pin_out    (dev_out),
    .programming_data_pin_oe_out (dev_oe),
    .config_word_one_out         (cw1),
    .config_word_two_out         (cw2),
    .config_word_three_out       (cw3),
    .config_loaded_out           (loaded)
  );

  prog_pin_model prog_pin_model_inst (
    .mclk_in     (mclk_in),
    .dev_data_in (dev_out),
    .dev_oe_in   (dev_oe),
    .pclk_out    (pclk),
    .pdata_out   (pdata)
  );

  always #10 mclk_in = ~mclk_in;

  // ==========================================================
  // Checking and ending
  task automatic check(input string name, input logic [15:0] seen, input logic [15:0] exp);
    n_checks++;
    if (seen !== exp) begin
      failures++;
      $display("ERROR %s expected %h seen %h", name, exp, seen);
    end
  endtask : check

  task automatic summarize();
    if (failures == 0 && n_checks > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask : summarize

  task automatic check_words(input logic [15:0] e1, input logic [15:0] e2,
                             input logic [15:0] e3);
    check("config_word_one", cw1, e1);
    check("config_word_two", cw2, e2);
    check("config_word_three", cw3, e3);
  endtask : check_words

  // Reset for 16 cycles, defaults shown while held, reload after release
  task automatic pulse_reset();
    rst_in <= 1'b1;
    repeat (16) @(posedge mclk_in);
    check("loaded_in_reset", {15'h0, loaded}, 16'h0000);
    check_words(16'h7fff, 16'hf7ff, 16'hffff);
    rst_in <= 1'b0;
    repeat (6) @(posedge mclk_in);
    check("loaded", {15'h0, loaded}, 16'h0001);
  endtask : pulse_reset

  initial begin
    repeat (100000) @(posedge mclk_in);
    failures++;
    summarize();
  end

  // ==========================================================
  // Main sequence
  initial begin
    logic fb;
    logic lb;
    logic [15:0] p1;
    logic [15:0] p2;
    logic [15:0] p3;
    mclk_in       = 1'b0;
    rst_in        = 1'b1;
    chip_erase_in = 1'b0;
    failures      = 0;
    n_checks      = 0;
    @(posedge mclk_in);
    chip_erase_in <= 1'b1;
    @(posedge mclk_in);
    chip_erase_in <= 1'b0;
    pulse_reset();
    check_words(16'h7fff, 16'hf7ff, 16'hffff);
    {p1, p2, p3} = {16'h7fff, 16'hf7ff, 16'hffff};
    foreach (ROWS[r]) begin
      prog_pin_model_inst.program_word(int'(ROWS[r].idx), ROWS[r].val, fb, lb);
      check("busy_first_poll", {15'h0, fb}, 16'h0001);
      check("busy_final_poll", {15'h0, lb}, 16'h0000);
      check_words(p1, p2, p3);
      pulse_reset();
      check_words(ROWS[r].e1, ROWS[r].e2, ROWS[r].e3);
      {p1, p2, p3} = {ROWS[r].e1, ROWS[r].e2, ROWS[r].e3};
    end
    // Erase alone changes nothing until the next reset
    chip_erase_in <= 1'b1;
    @(posedge mclk_in);
    chip_erase_in <= 1'b0;
    repeat (4) @(posedge mclk_in);
    check_words(p1, p2, p3);
    pulse_reset();
    check_words(16'h7fff, 16'hf7ff, 16'hffff);
    summarize();
  end
endmodule : tb_top
